// ===== rtl/tcic_capture_filter.sv
// optional noise filter on the selected capture source
`timescale 1ns/10ps
`include "tcic_regs.svh"

module tcic_capture_filter #(
    parameter int SAMPLES = `TC_FILT_SAMPLES
) (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic reset,
    // control and data
    input  wire logic filterEn,
    input  wire logic capIn,
    output logic      capOut
);

    logic [SAMPLES-1:0] hist_ff;
    logic               capOut_ff;

    // ==========================================================
    // sample history and output decision
    wire allHigh = &hist_ff;
    wire allLow  = ~|hist_ff;
    // the filtered path costs four extra cycles over the direct path [RULE6]
    wire nxt_capOut = filterEn ? (allHigh ? 1'b1 : (allLow ? 1'b0 : capOut_ff)) : capIn; // [RULE5]
    wire [SAMPLES-1:0] nxt_hist = {hist_ff[SAMPLES-2:0], capIn};

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            hist_ff   <= '0;
            capOut_ff <= 1'b0;
        end else begin
            hist_ff   <= nxt_hist;
            capOut_ff <= nxt_capOut;
        end
    end

    assign capOut = capOut_ff;

endmodule

// ===== rtl/tcic_pkg.sv
// types shared by the timer files
package tcic_pkg;

    typedef enum logic {
        TCIC_NORMAL,
        TCIC_CLEAR_ON_MATCH
    } tcic_wave_t;

    typedef struct packed {
        logic capture;
        logic cmpB;
        logic cmpA;
        logic overflow;
    } tcic_flags_t;

endpackage

// ===== rtl/tcic_regs.svh
// register offsets, field positions, reset values and counts of the timer
// What this block does
// (RULE1) four flags: overflow, compare A, compare B, capture
// (RULE2) 8-bit mode has two independent compare units
// (RULE3) 16-bit mode has only compare unit A
// (RULE4) clear-on-match mode clears counter on match
// (RULE5) filter needs four equal samples to change
// (RULE6) filter delays each capture by four cycles
// (RULE7) edge select: zero falling, one rising
// (RULE8) capture edge copies counter into capture register
// (RULE9) capture sets flag; enabled flag requests interrupt
// (RULE10) software writes zero to mode bit 3
// (RULE11) mode bits 2 and 1 read zero
// (RULE12) mode bit 0 picks normal or clear-on-match
// (RULE13) source bits 1:0 select; 7:2 read zero
// (RULE14) capture interrupt only when its mask bit set
// (RULE15) counter low byte is readable and writable
// (RULE16) counter write blocks match on next tick
// (RULE17) 16-bit mode: low byte is count bits 7:0
// (RULE18) normal mode wraps at maximum, sets overflow
// (RULE19) compare equality sets flag; A is top
`ifndef TCIC_REGS_SVH
`define TCIC_REGS_SVH

// ==========================================================
// register byte offsets
`define TC_OFF_MODE      12'h000
`define TC_OFF_SRC       12'h004
`define TC_OFF_CNTL      12'h008
`define TC_OFF_CNTH      12'h00c
`define TC_OFF_CMPA      12'h010
`define TC_OFF_CMPB      12'h014
`define TC_OFF_CAPT      12'h018
`define TC_OFF_FLAGS     12'h01c
`define TC_OFF_MASK      12'h020
`define TC_OFF_CFG       12'h024

// ==========================================================
// field positions
`define TC_MODE_FILT_BIT 5
`define TC_MODE_EDGE_BIT 4
`define TC_MODE_WAVE_BIT 0
`define TC_CFG_RUN_BIT   0
`define TC_CFG_WIDE_BIT  1

// ==========================================================
// reset values and counts
`define TC_SRC_RESET     2'h0
`define TC_CFG_RESET     2'h0
`define TC_CNT_RESET     16'h0000
`define TC_CMP_RESET     16'h0000
`define TC_FLAGS_RESET   4'h0
`define TC_TICK_DIV      8'h01
`define TC_FILT_SAMPLES  4

`endif

// ===== rtl/tcic_timer.sv
// timer/counter with two compare units, input capture and an apb slave
`timescale 1ns/10ps
`include "tcic_regs.svh"

module tcic_timer #(
    parameter logic [7:0] TICK_DIV = `TC_TICK_DIV,
    parameter int         SAMPLES  = `TC_FILT_SAMPLES
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // capture source pins
    input  wire logic [3:0]  captureSrc,
    // interrupt requests: capture, compare B, compare A, overflow
    output logic      [3:0]  irqReq
);

    // ==========================================================
    // state
    logic [31:0]             prdata_ff;
    logic                    pready_ff;
    logic                    pslverr_ff;
    logic [3:0]              irqReq_ff;
    logic                    filterEn_ff;
    logic                    edgeSel_ff;
    tcic_pkg::tcic_wave_t    wave_ff;
    logic [1:0]              srcSel_ff;
    logic [1:0]              cfg_ff;
    logic [15:0]             cnt_ff;
    logic [15:0]             cmpA_ff;
    logic [7:0]              cmpB_ff;
    logic [15:0]             capt_ff;
    tcic_pkg::tcic_flags_t   flags_ff;
    logic [3:0]              mask_ff;
    logic                    blockMatch_ff;
    logic [7:0]              divCnt_ff;
    logic [3:0]              sync1_ff;
    logic [3:0]              sync2_ff;
    logic                    capPrev_ff;
    logic                    capFilt;

    // ==========================================================
    // apb decode
    wire access  = psel & penable;
    wire wrEn    = access & pready_ff & pwrite;
    wire hitMode = (paddr == `TC_OFF_MODE);
    wire hitSrc  = (paddr == `TC_OFF_SRC);
    wire hitCntL = (paddr == `TC_OFF_CNTL);
    wire hitCntH = (paddr == `TC_OFF_CNTH);
    wire hitCmpA = (paddr == `TC_OFF_CMPA);
    wire hitCmpB = (paddr == `TC_OFF_CMPB);
    wire hitCapt = (paddr == `TC_OFF_CAPT);
    wire hitFlg  = (paddr == `TC_OFF_FLAGS);
    wire hitMask = (paddr == `TC_OFF_MASK);
    wire hitCfg  = (paddr == `TC_OFF_CFG);
    wire hitAny  = hitMode | hitSrc | hitCntL | hitCntH | hitCmpA | hitCmpB |
                   hitCapt | hitFlg | hitMask | hitCfg;
    wire wrMode  = wrEn & hitMode;
    wire wrSrc   = wrEn & hitSrc;
    wire wrCntL  = wrEn & hitCntL;
    wire wrCntH  = wrEn & hitCntH;
    wire wrCmpA  = wrEn & hitCmpA;
    wire wrCmpB  = wrEn & hitCmpB;
    wire wrFlg   = wrEn & hitFlg;
    wire wrMask  = wrEn & hitMask;
    wire wrCfg   = wrEn & hitCfg;
    wire wrCnt   = wrCntL | wrCntH;

    // one wait state: pready rises in the second access cycle
    wire nxt_pready  = access & ~pready_ff;

    // ==========================================================
    // read data
    // bit 3 is not stored, so a stray one written there has no effect [RULE10]
    wire [7:0] modeRd = {2'b00, filterEn_ff, edgeSel_ff, 3'b000, wave_ff}; // [RULE11]
    wire [7:0] srcRd  = {6'h00, srcSel_ff}; // [RULE13]
    wire [31:0] rdData =
        hitMode ? {24'h000000, modeRd} :
        hitSrc  ? {24'h000000, srcRd} :
        hitCntL ? {24'h000000, cnt_ff[7:0]} : // [RULE15]
        hitCntH ? {24'h000000, cnt_ff[15:8]} :
        hitCmpA ? {16'h0000, cmpA_ff} :
        hitCmpB ? {24'h000000, cmpB_ff} :
        hitCapt ? {16'h0000, capt_ff} :
        hitFlg  ? {28'h0000000, flags_ff} :
        hitMask ? {28'h0000000, mask_ff} :
        hitCfg  ? {30'h0, cfg_ff} : 32'h00000000;
    wire [31:0] nxt_prdata  = (nxt_pready & ~pwrite) ? rdData : 32'h00000000;
    wire        nxt_pslverr = nxt_pready & ~hitAny;

    // ==========================================================
    // timer clock enable from the divider
    wire       run     = cfg_ff[`TC_CFG_RUN_BIT];
    wire       wide    = cfg_ff[`TC_CFG_WIDE_BIT];
    wire       tick    = run & (divCnt_ff == (TICK_DIV - 8'h01));
    wire [7:0] nxt_div = (tick | ~run) ? 8'h00 : divCnt_ff + 8'h01;

    // ==========================================================
    // counter and compare
    wire        clear_on_match_mode     = (wave_ff == tcic_pkg::TCIC_CLEAR_ON_MATCH); // [RULE12]
    wire [15:0] cntVal  = wide ? cnt_ff : {8'h00, cnt_ff[7:0]}; // [RULE17]
    wire [15:0] cntMax  = wide ? 16'hffff : 16'h00ff;
    wire [15:0] cmpAVal = wide ? cmpA_ff : {8'h00, cmpA_ff[7:0]};
    wire        matchA  = tick & ~blockMatch_ff & (cntVal == cmpAVal); // [RULE16] [RULE19]
    // unit B exists only while the counter is eight bits wide
    wire        matchB  = tick & ~blockMatch_ff & ~wide & (cnt_ff[7:0] == cmpB_ff); // [RULE2] [RULE3]
    wire        atMax   = cntVal == cntMax;
    wire        ovfEvt  = tick & atMax; // [RULE18]
    wire        clrCnt  = clear_on_match_mode & matchA; // [RULE4]
    wire [15:0] cntInc  = (clrCnt | atMax) ? 16'h0000 : cntVal + 16'h0001;
    wire [15:0] cntWr   = wrCntL ? {cnt_ff[15:8], pwdata[7:0]} : {pwdata[7:0], cnt_ff[7:0]};
    // a software write wins over a tick in the same cycle
    wire [15:0] nxt_cnt = wrCnt ? cntWr : (tick ? cntInc : cnt_ff);
    wire        nxt_block = wrCnt | (blockMatch_ff & ~tick); // [RULE16]

    // ==========================================================
    // capture path: only the second sync stage is read
    wire capRaw   = sync2_ff[srcSel_ff]; // [RULE13]
    wire capEvent = edgeSel_ff ? (capFilt & ~capPrev_ff) : (~capFilt & capPrev_ff); // [RULE7]
    wire [15:0] nxt_capt = capEvent ? cntVal : capt_ff; // [RULE8]

    tcic_capture_filter #(
        .SAMPLES  (SAMPLES)
    ) u_filter (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .filterEn (filterEn_ff),
        .capIn    (capRaw),
        .capOut   (capFilt)
    );

    // ==========================================================
    // flags: a set in the same cycle as a clear wins
    wire [3:0] setVec  = {capEvent, matchB, matchA, ovfEvt}; // [RULE1] [RULE9]
    wire [3:0] clrVec  = wrFlg ? pwdata[3:0] : 4'h0;
    wire [3:0] nxt_flg = (flags_ff & ~clrVec) | setVec;
    wire [3:0] nxt_irq = flags_ff & mask_ff; // [RULE9] [RULE14]

    // ==========================================================
    // registers
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            prdata_ff  <= 32'h00000000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            prdata_ff  <= nxt_prdata;
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            filterEn_ff <= 1'b0;
            edgeSel_ff  <= 1'b0;
            wave_ff     <= tcic_pkg::TCIC_NORMAL;
            srcSel_ff   <= `TC_SRC_RESET;
            cfg_ff      <= `TC_CFG_RESET;
            mask_ff     <= `TC_FLAGS_RESET;
        end else begin
            if (wrMode) begin
                filterEn_ff <= pwdata[`TC_MODE_FILT_BIT];
                edgeSel_ff  <= pwdata[`TC_MODE_EDGE_BIT];
                wave_ff     <= tcic_pkg::tcic_wave_t'(pwdata[`TC_MODE_WAVE_BIT]);
            end
            if (wrSrc) srcSel_ff <= pwdata[1:0];
            if (wrCfg) cfg_ff <= pwdata[1:0];
            if (wrMask) mask_ff <= pwdata[3:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cnt_ff        <= `TC_CNT_RESET;
            cmpA_ff       <= `TC_CMP_RESET;
            cmpB_ff       <= 8'h00;
            blockMatch_ff <= 1'b0;
            divCnt_ff     <= 8'h00;
        end else begin
            cnt_ff        <= nxt_cnt;
            blockMatch_ff <= nxt_block;
            divCnt_ff     <= nxt_div;
            if (wrCmpA) cmpA_ff <= pwdata[15:0];
            if (wrCmpB) cmpB_ff <= pwdata[7:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sync1_ff   <= 4'h0;
            sync2_ff   <= 4'h0;
            capPrev_ff <= 1'b0;
            capt_ff    <= 16'h0000;
            flags_ff   <= tcic_pkg::tcic_flags_t'(`TC_FLAGS_RESET);
            irqReq_ff  <= 4'h0;
        end else begin
            sync1_ff   <= captureSrc;
            sync2_ff   <= sync1_ff;
            capPrev_ff <= capFilt;
            capt_ff    <= nxt_capt;
            flags_ff   <= tcic_pkg::tcic_flags_t'(nxt_flg);
            irqReq_ff  <= nxt_irq;
        end
    end

    assign prdata  = prdata_ff;
    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;
    assign irqReq  = irqReq_ff;

    // ==========================================================
    // assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence s_held_high;
        (!capFilt && $rose(capRaw)) ##0 (filterEn_ff && capRaw)[*4] ##1 filterEn_ff;
    endsequence

    sequence s_late_rise;
        !capFilt ##1 capFilt;
    endsequence

    a_flag_count: assert property ( // [RULE1]
        setVec != 4'h0 |=> (flags_ff & $past(setVec)) == $past(setVec))
        else $error("a flag event did not set its flag");

    a_cmpb_narrow: assert property ( // [RULE2]
        tick && !blockMatch_ff && !wide && cnt_ff[7:0] == cmpB_ff && !wrFlg
        |=> flags_ff.cmpB)
        else $error("compare B match lost in 8-bit mode");

    a_cmpb_wide_off: assert property ( // [RULE3]
        wide && !(flags_ff.cmpB) && !wrFlg |=> !flags_ff.cmpB)
        else $error("compare B flag set in 16-bit mode");

    a_ctc_clear: assert property ( // [RULE4]
        tick && clear_on_match_mode && !blockMatch_ff && cntVal == cmpAVal && !wrCnt
        |=> cnt_ff == 16'h0000 || (!wide && cnt_ff[7:0] == 8'h00))
        else $error("counter not cleared on match");

    a_filter_delay: assert property (s_held_high |-> s_late_rise) // [RULE5] [RULE6]
        else $error("filtered capture not exactly four cycles late");

    a_direct_path: assert property ( // [RULE6]
        !filterEn_ff && !capFilt && capRaw |=> capFilt)
        else $error("unfiltered capture input not passed in one cycle");

    a_edge_falling: assert property ( // [RULE7]
        !edgeSel_ff && $fell(capFilt) && !wrFlg |=> flags_ff.capture)
        else $error("falling edge did not capture");

    a_edge_rising: assert property ( // [RULE7]
        edgeSel_ff && $rose(capFilt) |=> flags_ff.capture)
        else $error("rising edge did not capture");

    a_capture_copy: assert property ( // [RULE8]
        capEvent |=> capt_ff == $past(cntVal))
        else $error("capture register does not hold the counter");

    a_irq_gate: assert property ( // [RULE9] [RULE14]
        ##1 irqReq_ff[3] == ($past(flags_ff.capture) && $past(mask_ff[3])))
        else $error("capture interrupt not gated by its mask");

    a_irq_masked: assert property ( // [RULE14]
        !mask_ff[3] |=> !irqReq_ff[3])
        else $error("masked capture interrupt raised");

    a_reserved_zero: assert property ( // [RULE11]
        pready_ff && !pwrite && hitMode |-> prdata_ff[3:1] == 3'b000)
        else $error("reserved mode bits read non-zero");

    a_source_zero: assert property ( // [RULE13]
        pready_ff && !pwrite && hitSrc |-> prdata_ff[7:2] == 6'h00)
        else $error("source register upper bits read non-zero");

    a_cnt_write: assert property ( // [RULE15]
        wrCntL |=> cnt_ff[7:0] == $past(pwdata[7:0]))
        else $error("counter low byte write lost");

    a_block_match: assert property ( // [RULE16]
        wrCntL ##1 (tick && !wrCnt) |-> !matchA && !matchB)
        else $error("match not blocked after counter write");

    a_wide_carry: assert property ( // [RULE17]
        tick && wide && !wrCnt && !clrCnt && cnt_ff == 16'h00ff |=> cnt_ff == 16'h0100)
        else $error("low byte did not carry in 16-bit mode");

    a_overflow_wrap: assert property ( // [RULE18]
        tick && atMax && !wrCnt && !wrFlg |=> flags_ff.overflow && cntVal == 16'h0000)
        else $error("overflow wrap wrong");

    a_cmpa_flag: assert property ( // [RULE19]
        matchA |=> flags_ff.cmpA)
        else $error("compare A match did not set its flag");

endmodule

// ===== tb/tcic_src_model.sv
// capture source pins driven on behalf of the outside signal
`timescale 1ns/10ps

module tcic_src_model (
    // clock
    input  wire logic       ref_clk,
    // pins
    output logic      [3:0] captureSrc
);
    // pins idle low so that leaving reset is never seen as an edge
    initial captureSrc = 4'h0;

    // pin changes just after a rising edge, like a synchronous source
    task automatic setPin(input int idx, input logic val);
        @(posedge ref_clk);
        captureSrc[idx] <= val;
    endtask
endmodule

// ===== tb/tcic_timer_bench.sv
// register-level bench of the timer with input capture
`timescale 1ns/10ps
`include "tcic_regs.svh"

module tcic_timer_bench;
    logic        ref_clk;
    logic        reset;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  captureSrc;
    logic [3:0]  irqReq;
    logic [31:0] rd;
    logic        lastErr;
    int          err_count;
    int          samples_checked;
    int          lat0;
    int          lat1;

    tcic_timer tcic_timer_i (
        .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .captureSrc(captureSrc),
        .irqReq(irqReq)
    );
    tcic_src_model tcic_src_model_i (.ref_clk(ref_clk), .captureSrc(captureSrc));

    // ==========================================================
    // checks and verdict
    task automatic complete_run();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic checkWord(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic checkFlag(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask

    // ==========================================================
    // apb master: an edge always passes before a new setup cycle
    task automatic apbXfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // no local limit: only the watchdog ends a wait for ready
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd      = prdata;
        lastErr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apbXfer(a, 1'b1, d);
    endtask

    task automatic readCheck(input logic [11:0] a, input logic [31:0] exp);
        apbXfer(a, 1'b0, 32'h0);
        checkWord(rd, exp);
    endtask

    // counts cycles until the capture request shows
    task automatic waitCapIrq(output int c);
        c = 0;
        while (irqReq[3] !== 1'b1 && c < 40) begin
            @(posedge ref_clk);
            c++;
        end
        if (irqReq[3] !== 1'b1) begin
            err_count++;
            $display("mismatch at %0t: no capture request", $time);
        end
    endtask

    // ==========================================================
    // clock, reset, watchdog
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    initial begin
        #(50 * 20000);
        err_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        complete_run();
    end

    // ==========================================================
    // tests
    initial begin
        reset   = 1'b1;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
        err_count = 0;
        samples_checked = 0;
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        readCheck(`TC_OFF_MODE, 32'h0);
        readCheck(`TC_OFF_SRC, 32'h0);
        readCheck(`TC_OFF_FLAGS, 32'h0);
        apbXfer(12'h0fc, 1'b0, 32'h0);
        checkFlag(lastErr, 1'b1);
        checkWord(rd, 32'h0);
        wr(`TC_OFF_MODE, 32'h37);
        readCheck(`TC_OFF_MODE, 32'h31);
        wr(`TC_OFF_SRC, 32'hffffffff);
        readCheck(`TC_OFF_SRC, 32'h3);
        wr(`TC_OFF_CNTL, 32'h42);
        readCheck(`TC_OFF_CNTL, 32'h42);
        // clear-on-match: A at 5 is top, B at 3 still matches below it
        wr(`TC_OFF_CMPA, 32'h5);
        wr(`TC_OFF_CMPB, 32'h3);
        wr(`TC_OFF_CNTL, 32'h0);
        wr(`TC_OFF_MODE, 32'h1);
        wr(`TC_OFF_CFG, 32'h1);
        wr(`TC_OFF_FLAGS, 32'hf);
        wr(`TC_OFF_MASK, 32'h6);
        repeat (20) @(posedge ref_clk);
        readCheck(`TC_OFF_FLAGS, 32'h6);
        checkWord({28'h0, irqReq}, 32'h6);
        apbXfer(`TC_OFF_CNTL, 1'b0, 32'h0);
        checkFlag(rd <= 32'h5, 1'b1);
        // writing the top value must not clear on the next tick
        wr(`TC_OFF_CNTL, 32'h5);
        apbXfer(`TC_OFF_CNTL, 1'b0, 32'h0);
        checkFlag(rd[7:0] > 8'h05, 1'b1);
        // 8-bit normal counting through the wrap
        wr(`TC_OFF_CFG, 32'h0);
        wr(`TC_OFF_MODE, 32'h0);
        wr(`TC_OFF_CNTL, 32'hf0);
        wr(`TC_OFF_FLAGS, 32'hf);
        wr(`TC_OFF_CFG, 32'h1);
        repeat (40) @(posedge ref_clk);
        wr(`TC_OFF_CFG, 32'h0);
        readCheck(`TC_OFF_FLAGS, 32'h7);
        apbXfer(`TC_OFF_CNTL, 1'b0, 32'h0);
        checkFlag(rd < 32'h40, 1'b1);
        // 16-bit: low byte carries into high byte, no compare B
        wr(`TC_OFF_CNTH, 32'h0);
        wr(`TC_OFF_CNTL, 32'hf0);
        wr(`TC_OFF_FLAGS, 32'hf);
        wr(`TC_OFF_CFG, 32'h3);
        repeat (40) @(posedge ref_clk);
        wr(`TC_OFF_CFG, 32'h0);
        readCheck(`TC_OFF_CNTH, 32'h1);
        readCheck(`TC_OFF_FLAGS, 32'h0);
        // capture on every source, with a decoy on the neighbour pin
        wr(`TC_OFF_CFG, 32'h2);
        wr(`TC_OFF_CFG, 32'h0);
        wr(`TC_OFF_CNTL, 32'h77);
        wr(`TC_OFF_MODE, 32'h10);
        wr(`TC_OFF_MASK, 32'h8);
        for (int s = 0; s < 4; s++) begin
            wr(`TC_OFF_SRC, 32'(s));
            wr(`TC_OFF_FLAGS, 32'hf);
            tcic_src_model_i.setPin((s + 1) % 4, 1'b1);
            tcic_src_model_i.setPin((s + 1) % 4, 1'b0);
            repeat (12) @(posedge ref_clk);
            readCheck(`TC_OFF_FLAGS, 32'h0);
            tcic_src_model_i.setPin(s, 1'b1);
            waitCapIrq(lat0);
            readCheck(`TC_OFF_CAPT, 32'h77);
            readCheck(`TC_OFF_FLAGS, 32'h8);
            tcic_src_model_i.setPin(s, 1'b0);
        end
        // falling edge select, interrupt masked
        wr(`TC_OFF_MODE, 32'h0);
        wr(`TC_OFF_MASK, 32'h0);
        wr(`TC_OFF_FLAGS, 32'hf);
        tcic_src_model_i.setPin(3, 1'b1);
        repeat (12) @(posedge ref_clk);
        readCheck(`TC_OFF_FLAGS, 32'h0);
        tcic_src_model_i.setPin(3, 1'b0);
        repeat (12) @(posedge ref_clk);
        readCheck(`TC_OFF_FLAGS, 32'h8);
        checkFlag(irqReq[3], 1'b0);
        // filter drops a three-cycle pulse and delays a real edge
        wr(`TC_OFF_MODE, 32'h30);
        wr(`TC_OFF_MASK, 32'h8);
        wr(`TC_OFF_FLAGS, 32'hf);
        tcic_src_model_i.setPin(3, 1'b1);
        repeat (2) @(posedge ref_clk);
        tcic_src_model_i.setPin(3, 1'b0);
        repeat (12) @(posedge ref_clk);
        readCheck(`TC_OFF_FLAGS, 32'h0);
        tcic_src_model_i.setPin(3, 1'b1);
        waitCapIrq(lat1);
        checkWord(32'(lat1 - lat0), 32'h4);
        complete_run();
    end
endmodule
